// ### hdl/tlic_defines.svh
// Constants for the three-level interrupt controller
`ifndef TLIC_DEFINES_SVH
`define TLIC_DEFINES_SVH

// Register indices; byte address is four times the index
`define TLIC_IDX_EN 10'h0a8
`define TLIC_IDX_EXT 10'h0a9
`define TLIC_IDX_IP 10'h0b8
`define TLIC_IDX_WD 10'h0c0
`define TLIC_IDX_STAT 10'h0d0
`define TLIC_IDX_MASK 10'h0d1
`define TLIC_IDX_STATE 10'h0d2
// Single-bit window: byte address 0x400 + bit address * 4
`define TLIC_BITWIN 2'h1
`define TLIC_BYTE_EN 5'h15
`define TLIC_BYTE_IP 5'h17
`define TLIC_BYTE_WD 5'h18

// Reset values
`define TLIC_RST_EN 8'h00
`define TLIC_RST_EXT 8'ha0
`define TLIC_RST_IP 8'h00
`define TLIC_RST_WD 8'h10
`define TLIC_EXT_WMASK 8'h5f

// Field positions
`define TLIC_GATE 7
`define TLIC_EN_TEMP 6
`define TLIC_EN_T2 5
`define TLIC_EN_UART 4
`define TLIC_EN_T1 3
`define TLIC_EN_X1 2
`define TLIC_EN_T0 1
`define TLIC_EN_X0 0
`define TLIC_IP_DSP 7
`define TLIC_EX_RTCLV 6
`define TLIC_EX_SPILV 4
`define TLIC_EX_DSP 3
`define TLIC_EX_RTC 2
`define TLIC_EX_SUP 1
`define TLIC_EX_SPI 0

// Sources in polling order, 0 is served first
`define TLIC_NSRC 12
`define TLIC_S_SUP 0
`define TLIC_S_RTC 1
`define TLIC_S_DSP 2
`define TLIC_S_WDT 3
`define TLIC_S_TEMP 4
`define TLIC_S_X0 5
`define TLIC_S_T0 6
`define TLIC_S_X1 7
`define TLIC_S_T1 8
`define TLIC_S_SPI 9
`define TLIC_S_UART 10
`define TLIC_S_T2 11

// Vector table: base plus eight bytes per slot
`define TLIC_VEC_BASE 16'h0003
`define TLIC_V_X0 4'h0
`define TLIC_V_T0 4'h1
`define TLIC_V_X1 4'h2
`define TLIC_V_T1 4'h3
`define TLIC_V_UART 4'h4
`define TLIC_V_T2 4'h5
`define TLIC_V_TEMP 4'h6
`define TLIC_V_SPI 4'h7
`define TLIC_V_SUP 4'h8
`define TLIC_V_DSP 4'h9
`define TLIC_V_RTC 4'ha
`define TLIC_V_WDT 4'hb

// Sticky event bits
`define TLIC_EV_TAKEN 0
`define TLIC_EV_RETURN 1
`define TLIC_EV_NEST 2
`define TLIC_RESP_OK 2'h0
`define TLIC_RESP_ERR 2'h2

`endif

// ### hdl/tlic_pkg.sv
// Types shared by the interrupt controller files
package tlic_pkg;
   typedef enum logic [1:0] {TLIC_LOW, TLIC_HIGH, TLIC_SUP} tlic_level_e;
   typedef struct packed {
      logic valid;
      tlic_level_e lvl;
      logic [3:0] src;
   } tlic_pick_t;
endpackage

// ### hdl/tlic_arbiter.sv
// Picks the highest-level pending source, lowest polling index on a tie
`timescale 1ns/10ps
module tlic_arbiter (
   input wire logic [11:0] i_pend,          // Gated pending requests
   input wire logic [23:0] i_lvl,           // Two level bits per source
   output tlic_pkg::tlic_pick_t o_pick      // Winning source
);
   // Walk from the highest polling index downward so index 0 wins ties
   always_comb begin
      o_pick = '0;
      for (int i = 11; i >= 0; i--) begin
         if (i_pend[i] && (!o_pick.valid || i_lvl[2*i +: 2] >= o_pick.lvl)) begin
            o_pick.valid = 1'b1;
            o_pick.lvl = tlic_pkg::tlic_level_e'(i_lvl[2*i +: 2]);
            o_pick.src = 4'(i);
         end
      end
   end
endmodule // tlic_arbiter

// ### hdl/tlic_top.sv
// Three-level vectored interrupt controller with AXI4-Lite registers
// How it works
// RL1: Supply-monitor request sits alone on a top level preempting any low or high routine.
// RL2: Two programmable levels stay; supply-monitor level is a separate third one.
// RL3: Main enable bit 7 gates every source; clear means nothing is taken.
// RL4: Main enable bits 6..0 enable temp, timer2, uart, timer1, pin1, timer0, pin0.
// RL5: Main level bits 7..0 pick high or low for eight sources.
// RL6: Extension bit 6 sets clock level, bit 4 serial-peripheral level.
// RL7: Extension bits 3..0 enable dsp, clock, supply monitor, serial peripheral.
// RL8: Extension register resets to 0xa0, byte access only, bits 7,5 reserved.
// RL9: Main enable resets to zero, single bits reachable at 0xa8..0xaf.
// RL10: Main level resets to zero, single bits reachable at 0xb8..0xbf.
// RL11: Same-level requests are served in fixed polling order.
// RL12: Watchdog control at 0xc0, resets to 0x10, single-bit access.
// RL13: High preempts low and beats it; never preempt own level.
// RL14: Accepted source gets fixed vector 0x0003 plus eight per slot.
// RL15: Forward only enabled, gated requests above every active level.
// RL16: Track active levels; return-from-interrupt releases the current one.
`timescale 1ns/10ps
`include "tlic_defines.svh"
module tlic_top (
   input wire logic I_CLOCK,                // Core clock
   input wire logic I_RESET_N,              // Synchronous reset, low
   input wire logic [11:0] I_REQ,           // Source requests, polling order
   input wire logic I_IRQ_ACK,              // Core takes the offered request
   input wire logic I_IRQ_RETI,             // Core leaves a routine
   output logic O_IRQ_REQ,                  // Request to the core
   output logic [15:0] O_IRQ_VECTOR,        // Vector of the offered source
   output logic [3:0] O_IRQ_SRC,            // Polling index offered
   output logic [1:0] O_IRQ_LEVEL,          // Level offered
   output logic [7:0] O_WDT_CONTROL,        // Watchdog control byte
   output logic O_INT,                      // OR of event status bits enabled in mask
   input wire logic [11:0] I_AXI_AWADDR,    // Write address
   input wire logic I_AXI_AWVALID,          // Write address valid
   output logic O_AXI_AWREADY,              // Write address ready
   input wire logic [31:0] I_AXI_WDATA,     // Write data
   input wire logic [3:0] I_AXI_WSTRB,      // Write strobes
   input wire logic I_AXI_WVALID,           // Write data valid
   output logic O_AXI_WREADY,               // Write data ready
   output logic [1:0] O_AXI_BRESP,          // Write response
   output logic O_AXI_BVALID,               // Write response valid
   input wire logic I_AXI_BREADY,           // Write response ready
   input wire logic [11:0] I_AXI_ARADDR,    // Read address
   input wire logic I_AXI_ARVALID,          // Read address valid
   output logic O_AXI_ARREADY,              // Read address ready
   output logic [31:0] O_AXI_RDATA,         // Read data
   output logic [1:0] O_AXI_RRESP,          // Read response
   output logic O_AXI_RVALID,               // Read data valid
   input wire logic I_AXI_RREADY            // Read data ready
);
   logic [7:0] irq_enable_main;
   logic [7:0] irq_enable_level_ext;
   logic [7:0] irq_level_main;
   logic [7:0] watchdog_control;
   logic [2:0] stat;
   logic [2:0] mask;
   logic [2:0] act;
   logic aw_held;
   logic w_held;
   logic [11:0] aw_addr;
   logic [7:0] w_byte;
   logic w_lane0;
   tlic_pkg::tlic_pick_t pick;

   // Write channel bookkeeping
   wire do_wr = aw_held && w_held && !O_AXI_BVALID;
   wire [9:0] w_idx = aw_addr[11:2];
   wire w_bitwin = aw_addr[11:10] == `TLIC_BITWIN;
   wire [7:0] w_ba = aw_addr[9:2];
   wire wr_ok = do_wr && w_lane0;
   wire wr_en = wr_ok && !w_bitwin && w_idx == `TLIC_IDX_EN;
   wire wr_ext = wr_ok && !w_bitwin && w_idx == `TLIC_IDX_EXT;
   wire wr_ip = wr_ok && !w_bitwin && w_idx == `TLIC_IDX_IP;
   wire wr_wd = wr_ok && !w_bitwin && w_idx == `TLIC_IDX_WD;
   wire wr_stat = wr_ok && !w_bitwin && w_idx == `TLIC_IDX_STAT;
   wire wr_mask = wr_ok && !w_bitwin && w_idx == `TLIC_IDX_MASK;
   wire bit_en = wr_ok && w_bitwin && w_ba[7:3] == `TLIC_BYTE_EN;
   wire bit_ip = wr_ok && w_bitwin && w_ba[7:3] == `TLIC_BYTE_IP;
   wire bit_wd = wr_ok && w_bitwin && w_ba[7:3] == `TLIC_BYTE_WD;
   wire w_known = (w_bitwin && w_ba[7:3] inside {`TLIC_BYTE_EN, `TLIC_BYTE_IP,
      `TLIC_BYTE_WD}) || (!w_bitwin && w_idx inside {`TLIC_IDX_EN, `TLIC_IDX_EXT,
      `TLIC_IDX_IP, `TLIC_IDX_WD, `TLIC_IDX_STAT, `TLIC_IDX_MASK, `TLIC_IDX_STATE});
   wire [7:0] bit_sel = 8'h01 << w_ba[2:0];

   // Single-bit writes set or clear one bit from write data bit 0
   function automatic logic [7:0] bitwr(input logic [7:0] r, input logic [7:0] m,
                                        input logic v);
      bitwr = v ? (r | m) : (r & ~m);
   endfunction

   // Next values of the software registers
   wire [7:0] next_en = wr_en ? w_byte :
      bit_en ? bitwr(irq_enable_main, bit_sel, w_byte[0]) : irq_enable_main; // [RL9]
   wire [7:0] next_ip = wr_ip ? w_byte :
      bit_ip ? bitwr(irq_level_main, bit_sel, w_byte[0]) : irq_level_main; // [RL10]
   wire [7:0] next_wd = wr_wd ? w_byte :
      bit_wd ? bitwr(watchdog_control, bit_sel, w_byte[0]) : watchdog_control; // [RL12]
   wire [7:0] next_ext = wr_ext ? ((w_byte & `TLIC_EXT_WMASK) |
      (`TLIC_RST_EXT & ~`TLIC_EXT_WMASK)) : irq_enable_level_ext; // [RL8]

   // Per-source enables in polling order
   wire [11:0] src_en;
   assign src_en[`TLIC_S_SUP] = irq_enable_level_ext[`TLIC_EX_SUP]; // [RL7]
   assign src_en[`TLIC_S_RTC] = irq_enable_level_ext[`TLIC_EX_RTC]; // [RL7]
   assign src_en[`TLIC_S_DSP] = irq_enable_level_ext[`TLIC_EX_DSP]; // [RL7]
   assign src_en[`TLIC_S_WDT] = 1'b1; // Watchdog relies on the gate only
   assign src_en[`TLIC_S_TEMP] = irq_enable_main[`TLIC_EN_TEMP]; // [RL4]
   assign src_en[`TLIC_S_X0] = irq_enable_main[`TLIC_EN_X0]; // [RL4]
   assign src_en[`TLIC_S_T0] = irq_enable_main[`TLIC_EN_T0]; // [RL4]
   assign src_en[`TLIC_S_X1] = irq_enable_main[`TLIC_EN_X1]; // [RL4]
   assign src_en[`TLIC_S_T1] = irq_enable_main[`TLIC_EN_T1]; // [RL4]
   assign src_en[`TLIC_S_SPI] = irq_enable_level_ext[`TLIC_EX_SPI]; // [RL7]
   assign src_en[`TLIC_S_UART] = irq_enable_main[`TLIC_EN_UART]; // [RL4]
   assign src_en[`TLIC_S_T2] = irq_enable_main[`TLIC_EN_T2]; // [RL4]

   // Programmable high bit per source; supply monitor and watchdog are fixed apart
   wire [11:0] hi;
   assign hi[`TLIC_S_SUP] = 1'b0;
   assign hi[`TLIC_S_RTC] = irq_enable_level_ext[`TLIC_EX_RTCLV]; // [RL6]
   assign hi[`TLIC_S_DSP] = irq_level_main[`TLIC_IP_DSP]; // [RL5]
   assign hi[`TLIC_S_WDT] = 1'b0;
   assign hi[`TLIC_S_TEMP] = irq_level_main[`TLIC_EN_TEMP]; // [RL5]
   assign hi[`TLIC_S_X0] = irq_level_main[`TLIC_EN_X0]; // [RL5]
   assign hi[`TLIC_S_T0] = irq_level_main[`TLIC_EN_T0]; // [RL5]
   assign hi[`TLIC_S_X1] = irq_level_main[`TLIC_EN_X1]; // [RL5]
   assign hi[`TLIC_S_T1] = irq_level_main[`TLIC_EN_T1]; // [RL5]
   assign hi[`TLIC_S_SPI] = irq_enable_level_ext[`TLIC_EX_SPILV]; // [RL6]
   assign hi[`TLIC_S_UART] = irq_level_main[`TLIC_EN_UART]; // [RL5]
   assign hi[`TLIC_S_T2] = irq_level_main[`TLIC_EN_T2]; // [RL5]

   // Level per source: supply monitor on its own third level
   wire [23:0] lvl_vec;
   genvar g;
   generate
      for (g = 0; g < `TLIC_NSRC; g++) begin : g_lvl
         assign lvl_vec[2*g +: 2] = (g == `TLIC_S_SUP) ? 2'(tlic_pkg::TLIC_SUP) :
            hi[g] ? 2'(tlic_pkg::TLIC_HIGH) : 2'(tlic_pkg::TLIC_LOW); // [RL1] [RL2]
      end
   endgenerate

   wire gate = irq_enable_main[`TLIC_GATE];
   wire [11:0] pend = I_REQ & src_en & {12{gate}}; // [RL3] [RL15]

   tlic_arbiter u_arb (
      .i_pend(pend),
      .i_lvl(lvl_vec),
      .o_pick(pick)
   ); // [RL11]

   // Offer only above every active level; never the same level
   wire above = !act[tlic_pkg::TLIC_SUP] && (pick.lvl == tlic_pkg::TLIC_SUP ||
      (!act[tlic_pkg::TLIC_HIGH] && (pick.lvl == tlic_pkg::TLIC_HIGH ||
      !act[tlic_pkg::TLIC_LOW]))); // [RL13] [RL15]
   wire taken = O_IRQ_REQ && I_IRQ_ACK;
   wire next_req = pick.valid && above && !taken && !I_IRQ_RETI; // [RL15]

   // Vector slot of each polling index
   function automatic logic [3:0] slot(input logic [3:0] s);
      case (s)
         4'(`TLIC_S_SUP): slot = `TLIC_V_SUP;
         4'(`TLIC_S_RTC): slot = `TLIC_V_RTC;
         4'(`TLIC_S_DSP): slot = `TLIC_V_DSP;
         4'(`TLIC_S_WDT): slot = `TLIC_V_WDT;
         4'(`TLIC_S_TEMP): slot = `TLIC_V_TEMP;
         4'(`TLIC_S_X0): slot = `TLIC_V_X0;
         4'(`TLIC_S_T0): slot = `TLIC_V_T0;
         4'(`TLIC_S_X1): slot = `TLIC_V_X1;
         4'(`TLIC_S_T1): slot = `TLIC_V_T1;
         4'(`TLIC_S_SPI): slot = `TLIC_V_SPI;
         4'(`TLIC_S_UART): slot = `TLIC_V_UART;
         default: slot = `TLIC_V_T2;
      endcase
   endfunction
   wire [15:0] next_vec = `TLIC_VEC_BASE + {9'h000, slot(pick.src), 3'h0}; // [RL14]

   // Active levels: return drops the highest, acceptance marks the offered one
   logic [2:0] act_drop;
   assign act_drop = act[2] ? 3'h4 : act[1] ? 3'h2 : act[0] ? 3'h1 : 3'h0;
   wire [2:0] act_take = taken ? (3'h1 << O_IRQ_LEVEL) : 3'h0;
   wire [2:0] next_act = (act & ~(I_IRQ_RETI ? act_drop : 3'h0)) | act_take; // [RL16]

   // Events: set wins over write-one-to-clear
   wire [2:0] ev = {taken && |act, I_IRQ_RETI, taken};
   wire [2:0] next_stat = (stat & ~(wr_stat ? w_byte[2:0] : 3'h0)) | ev;

   // Interrupt offer to the core
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         O_IRQ_REQ <= 1'b0;
         O_IRQ_VECTOR <= 16'h0000;
         O_IRQ_SRC <= 4'h0;
         O_IRQ_LEVEL <= 2'h0;
         act <= 3'h0;
      end else begin
         O_IRQ_REQ <= next_req;
         O_IRQ_VECTOR <= next_vec;
         O_IRQ_SRC <= pick.src;
         O_IRQ_LEVEL <= pick.lvl;
         act <= next_act;
      end
   end

   // Software registers and event status
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         irq_enable_main <= `TLIC_RST_EN;
         irq_enable_level_ext <= `TLIC_RST_EXT;
         irq_level_main <= `TLIC_RST_IP;
         watchdog_control <= `TLIC_RST_WD;
         stat <= 3'h0;
         mask <= 3'h0;
      end else begin
         irq_enable_main <= next_en;
         irq_enable_level_ext <= next_ext;
         irq_level_main <= next_ip;
         watchdog_control <= next_wd;
         stat <= next_stat;
         mask <= wr_mask ? w_byte[2:0] : mask;
      end
   end

   assign O_INT = |(stat & mask);
   assign O_WDT_CONTROL = watchdog_control;
   assign O_AXI_AWREADY = !aw_held && !O_AXI_BVALID;
   assign O_AXI_WREADY = !w_held && !O_AXI_BVALID;
   assign O_AXI_ARREADY = !O_AXI_RVALID;

   // Write address and data are taken in either order
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         aw_held <= 1'b0;
         w_held <= 1'b0;
         aw_addr <= 12'h000;
         w_byte <= 8'h00;
         w_lane0 <= 1'b0;
         O_AXI_BVALID <= 1'b0;
         O_AXI_BRESP <= `TLIC_RESP_OK;
      end else begin
         if (I_AXI_AWVALID && O_AXI_AWREADY) begin
            aw_held <= 1'b1;
            aw_addr <= I_AXI_AWADDR;
         end else if (do_wr) begin
            aw_held <= 1'b0;
         end
         if (I_AXI_WVALID && O_AXI_WREADY) begin
            w_held <= 1'b1;
            w_byte <= I_AXI_WDATA[7:0];
            w_lane0 <= I_AXI_WSTRB[0];
         end else if (do_wr) begin
            w_held <= 1'b0;
         end
         if (do_wr) begin
            O_AXI_BVALID <= 1'b1;
            O_AXI_BRESP <= w_known ? `TLIC_RESP_OK : `TLIC_RESP_ERR;
         end else if (I_AXI_BREADY) begin
            O_AXI_BVALID <= 1'b0;
         end
      end
   end

   // Read decode
   wire [9:0] r_idx = I_AXI_ARADDR[11:2];
   wire [7:0] r_ba = I_AXI_ARADDR[9:2];
   wire r_bitwin = I_AXI_ARADDR[11:10] == `TLIC_BITWIN;
   wire [7:0] r_bsrc = r_ba[7:3] == `TLIC_BYTE_EN ? irq_enable_main :
      r_ba[7:3] == `TLIC_BYTE_IP ? irq_level_main : watchdog_control;
   wire r_bhit = r_ba[7:3] inside {`TLIC_BYTE_EN, `TLIC_BYTE_IP, `TLIC_BYTE_WD};
   wire [7:0] r_word = r_idx == `TLIC_IDX_EN ? irq_enable_main :
      r_idx == `TLIC_IDX_EXT ? irq_enable_level_ext :
      r_idx == `TLIC_IDX_IP ? irq_level_main :
      r_idx == `TLIC_IDX_WD ? watchdog_control :
      r_idx == `TLIC_IDX_STAT ? {5'h00, stat} :
      r_idx == `TLIC_IDX_MASK ? {5'h00, mask} :
      r_idx == `TLIC_IDX_STATE ? {1'b0, act, O_IRQ_SRC} : 8'h00;
   wire r_whit = r_idx inside {`TLIC_IDX_EN, `TLIC_IDX_EXT, `TLIC_IDX_IP,
      `TLIC_IDX_WD, `TLIC_IDX_STAT, `TLIC_IDX_MASK, `TLIC_IDX_STATE};
   wire r_hit = r_bitwin ? r_bhit : r_whit;
   wire [7:0] r_val = r_bitwin ? {7'h00, r_bsrc[r_ba[2:0]]} : r_word;

   // Read answer one cycle after the address is taken
   always_ff @(posedge I_CLOCK) begin
      if (!I_RESET_N) begin
         O_AXI_RVALID <= 1'b0;
         O_AXI_RDATA <= 32'h00000000;
         O_AXI_RRESP <= `TLIC_RESP_OK;
      end else if (I_AXI_ARVALID && O_AXI_ARREADY) begin
         O_AXI_RVALID <= 1'b1;
         O_AXI_RDATA <= {24'h000000, r_hit ? r_val : 8'h00};
         O_AXI_RRESP <= r_hit ? `TLIC_RESP_OK : `TLIC_RESP_ERR;
      end else if (I_AXI_RREADY) begin
         O_AXI_RVALID <= 1'b0;
      end
   end

   // Checks on the offer, levels and registers
   default clocking cb @(posedge I_CLOCK); endclocking
   default disable iff (!I_RESET_N);
   wire hi_pend = |(pend & hi);
   AST_GATE: assert property (!gate |=> !O_IRQ_REQ) // [RL3]
      else $error("request offered with global gate clear");
   AST_SUP_ONLY: assert property (O_IRQ_REQ && act[1] |-> O_IRQ_LEVEL == 2'(tlic_pkg::TLIC_SUP)
                                  && O_IRQ_SRC == 4'(`TLIC_S_SUP)) // [RL1]
      else $error("high routine preempted by non supply-monitor source");
   AST_ABOVE: assert property (O_IRQ_REQ |-> (act >> O_IRQ_LEVEL) == 3'h0) // [RL15]
      else $error("request offered at or below an active level");
   AST_HI_WINS: assert property (O_IRQ_REQ && O_IRQ_LEVEL == 2'(tlic_pkg::TLIC_LOW)
                                 |-> !$past(hi_pend)) // [RL13]
      else $error("low request chosen over a high one");
   AST_SUP_FIRST: assert property (pend[`TLIC_S_SUP] && !act[2] && !taken && !I_IRQ_RETI
                                   |=> O_IRQ_REQ && O_IRQ_SRC == 4'(`TLIC_S_SUP)) // [RL11]
      else $error("supply monitor not served first");
   AST_VEC: assert property (O_IRQ_REQ && O_IRQ_SRC == 4'(`TLIC_S_X0)
                             |-> O_IRQ_VECTOR == `TLIC_VEC_BASE) // [RL14]
      else $error("pin zero vector wrong");
   AST_VEC_WDT: assert property (O_IRQ_REQ && O_IRQ_SRC == 4'(`TLIC_S_WDT)
                                 |-> O_IRQ_VECTOR == 16'h005b) // [RL14]
      else $error("watchdog vector wrong");
   AST_TAKE: assert property (taken && !I_IRQ_RETI |=> act[$past(O_IRQ_LEVEL)]) // [RL16]
      else $error("accepted level not marked active");
   AST_RET: assert property (I_IRQ_RETI && act[2] && !taken |=> !act[2] ##1 1) // [RL16]
      else $error("return did not release the top level");
   AST_RSV: assert property (irq_enable_level_ext[7] && irq_enable_level_ext[5]) // [RL8]
      else $error("reserved bits of extension register changed");
   AST_RST: assert property ($past(!I_RESET_N) |-> irq_enable_main == `TLIC_RST_EN
      && irq_level_main == `TLIC_RST_IP && watchdog_control == `TLIC_RST_WD) // [RL9] [RL10] [RL12]
      else $error("register reset value wrong");
   AST_STICKY: assert property (taken |=> stat[`TLIC_EV_TAKEN]) // [RL16]
      else $error("taken event lost");
   COV_SUP_NEST: cover property (taken && act[1] && O_IRQ_LEVEL == 2'(tlic_pkg::TLIC_SUP));
   COV_HI_OVER_LO: cover property (taken && act[0] && O_IRQ_LEVEL == 2'(tlic_pkg::TLIC_HIGH));
   COV_BIT_WRITE: cover property (bit_en && w_byte[0]);
   COV_RETURN: cover property (I_IRQ_RETI && act[0] ##1 act == 3'h0);
endmodule // tlic_top

// ### tb/tlic_core_model.sv
// Core model that takes offered interrupts and returns from routines
`timescale 1ns/10ps
module tlic_core_model (
   input wire logic i_clock,       // Core clock
   input wire logic i_reset_n,     // Synchronous reset, low
   input wire logic i_req,         // Offered request
   input wire logic [1:0] i_delay, // Cycles before taking
   input wire logic [5:0] i_hold,  // Routine length in cycles
   output logic o_ack,             // Take pulse
   output logic o_reti,            // Return pulse
   output logic o_busy             // Some routine under way
);
   logic [3:0] depth;
   logic [5:0] t;
   logic [1:0] w;
   assign o_busy = (depth != 4'h0);
   // Take after a delay; return when the routine time runs out, innermost first
   always_ff @(posedge i_clock) begin
      if (!i_reset_n) begin
         o_ack <= 1'b0;
         o_reti <= 1'b0;
         depth <= 4'h0;
         t <= 6'h0;
         w <= 2'h0;
      end else begin
         o_ack <= 1'b0;
         o_reti <= 1'b0;
         if (o_ack) begin
            depth <= depth + 4'h1;
            t <= i_hold;
            w <= 2'h0;
         end else if (o_busy && t == 6'h0) begin
            o_reti <= 1'b1;
            depth <= depth - 4'h1;
         end else begin
            if (t != 6'h0) t <= t - 6'h1;
            if (i_req && !o_reti) begin
               if (w >= i_delay) o_ack <= 1'b1;
               else w <= w + 2'h1;
            end
         end
      end
   end
endmodule // tlic_core_model

// ### tb/tb_top.sv
// Self-checking bench for the interrupt controller
`timescale 1ns/10ps
module tb_top;
   logic clk, rst_n, ack, reti, busy, irq, o_int, awv, wv, bv, arv, rv, awr, wr, arr;
   logic [11:0] req, awa, ara;
   logic [31:0] wd, rd, rng;
   logic [3:0] src, ws;
   logic [1:0] lvl, br, rr, dly;
   logic [15:0] vec;
   logic [7:0] wdt, v;
   logic [5:0] hold;
   logic [33:0] rq[$];
   logic [21:0] iq[$];
   int err_total, samples_checked, n, i;
   localparam logic [3:0] SLOT [12] = '{8, 10, 9, 11, 6, 0, 1, 2, 3, 7, 4, 5};
   tlic_top i_dut (.I_CLOCK(clk), .I_RESET_N(rst_n), .I_REQ(req), .I_IRQ_ACK(ack),
      .I_IRQ_RETI(reti), .O_IRQ_REQ(irq), .O_IRQ_VECTOR(vec), .O_IRQ_SRC(src),
      .O_IRQ_LEVEL(lvl), .O_WDT_CONTROL(wdt), .O_INT(o_int), .I_AXI_AWADDR(awa),
      .I_AXI_AWVALID(awv), .O_AXI_AWREADY(awr), .I_AXI_WDATA(wd), .I_AXI_WSTRB(ws),
      .I_AXI_WVALID(wv), .O_AXI_WREADY(wr), .O_AXI_BRESP(br), .O_AXI_BVALID(bv),
      .I_AXI_BREADY(1'b1), .I_AXI_ARADDR(ara), .I_AXI_ARVALID(arv), .O_AXI_ARREADY(arr),
      .O_AXI_RDATA(rd), .O_AXI_RRESP(rr), .O_AXI_RVALID(rv), .I_AXI_RREADY(1'b1));
   tlic_core_model i_core (.i_clock(clk), .i_reset_n(rst_n), .i_req(irq), .i_delay(dly),
      .i_hold(hold), .o_ack(ack), .o_reti(reti), .o_busy(busy));
   // Clock at 25 MHz
   initial begin
      clk = 1'b0;
      forever #20 clk = ~clk;
   end
   function automatic logic [31:0] xs(input logic [31:0] s);
      s ^= s << 13;
      s ^= s >> 17;
      s ^= s << 5;
      return s;
   endfunction
   function automatic logic [21:0] ex(input int s, input logic [1:0] l);
      return {l, 4'(s), 16'h0003 + {9'h0, SLOT[s], 3'h0}};
   endfunction
   task automatic results();
      $display("checks %0d mismatches %0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask
   task automatic chk(input logic [33:0] e, input logic [33:0] g);
      samples_checked++;
      if (e !== g) begin
         err_total++;
         $display("ERROR at %0t expected %h got %h", $time, e, g);
      end
   endtask
   task automatic chk_rd(input logic [33:0] e, input logic [33:0] g); chk(e, g); endtask
   task automatic chk_irq(input logic [21:0] e, input logic [21:0] g); chk(34'(e), 34'(g)); endtask
   task automatic chk_sig(input logic [7:0] e, input logic [7:0] g); chk(34'(e), 34'(g)); endtask
   task automatic tmo(); err_total++; results(); endtask
   // Register write, address and data offered together
   task automatic wr_reg(input logic [11:0] a, input logic [7:0] d);
      logic ta, tw, b;
      rq.push_back(34'h0);
      awa <= a;
      wd <= {24'h0, d};
      awv <= 1'b1;
      wv <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge clk) {ta, tw, b} = {awv & awr, wv & wr, bv};
         @(posedge clk) if (ta) awv <= 1'b0;
         if (tw) wv <= 1'b0;
         if (b) break;
      end
      if (n == 50) tmo();
   endtask
   task automatic rd_reg(input logic [11:0] a, input logic [33:0] e);
      logic ta, b;
      rq.push_back(e);
      ara <= a;
      arv <= 1'b1;
      for (n = 0; n < 50; n++) begin
         @(negedge clk) {ta, b} = {arv & arr, rv};
         @(posedge clk) if (ta) arv <= 1'b0;
         if (b) break;
      end
      if (n == 50) tmo();
   endtask
   task automatic drain(input int k);
      for (n = 0; n < 3000; n++) begin
         @(posedge clk) if (iq.size() == k && !busy && irq !== 1'b1) break;
      end
      if (n == 3000) tmo();
   endtask
   // Random take delay for the core model
   always @(posedge clk) begin
      rng <= xs(rng);
      dly <= rng[1:0];
   end
   // Output watcher: bus answers and taken interrupts against the oldest note
   always @(posedge clk) begin
      if (rv === 1'b1) chk_rd(rq.pop_front(), {rr, rd});
      if (bv === 1'b1) chk_rd(rq.pop_front(), {br, 32'h0});
      if (irq === 1'b1 && ack === 1'b1) begin
         chk_irq(iq.pop_front(), {lvl, src, vec});
         req <= req & ~(12'h1 << src);
      end
   end
   // Main sequence
   initial begin
      {rst_n, awv, wv, arv, awa, ara, wd, req} = '0;
      {err_total, samples_checked} = 0;
      {ws, hold, rng} = {4'hf, 6'd8, 32'h4ca6};
      repeat (16) @(posedge clk);
      rst_n <= 1'b1;
      rd_reg(12'h2a0, 34'h0);
      rd_reg(12'h2a4, 34'ha0);
      rd_reg(12'h2e0, 34'h0);
      rd_reg(12'h300, 34'h10);
      rd_reg(12'h3f0, {2'h2, 32'h0});
      wr_reg(12'h2a4, 8'h00);
      rd_reg(12'h2a4, 34'ha0);
      v = rng[7:0];
      wr_reg(12'h300, v);
      chk_sig(v, wdt);
      wr_reg(12'h700, {7'h0, ~v[0]});
      chk_sig({v[7:1], ~v[0]}, wdt);
      $display("test registers done");
      wr_reg(12'h2a0, 8'h01);
      wr_reg(12'h344, 8'h01);
      req <= 12'h020;
      repeat (20) @(posedge clk);
      chk_sig({7'h0, irq}, 8'h0);
      iq.push_back(ex(5, 2'h0));
      wr_reg(12'h6bc, 8'h01);
      drain(0);
      rd_reg(12'h2a0, 34'h81);
      chk_sig({7'h0, o_int}, 8'h1);
      wr_reg(12'h340, 8'h07);
      chk_sig({7'h0, o_int}, 8'h0);
      $display("test gate done");
      wr_reg(12'h2a0, 8'hff);
      wr_reg(12'h2a4, 8'h0f);
      for (i = 1; i < 12; i++) iq.push_back(ex(i, 2'h0));
      req <= 12'hffe;
      drain(0);
      $display("test polling done");
      wr_reg(12'h2a4, 8'h1f);
      iq.push_back(ex(9, 2'h1));
      iq.push_back(ex(2, 2'h0));
      req <= 12'h204;
      drain(0);
      wr_reg(12'h2a4, 8'h0f);
      wr_reg(12'h2e0, 8'ha0);
      iq.push_back(ex(2, 2'h1));
      iq.push_back(ex(1, 2'h0));
      req <= 12'h006;
      drain(0);
      $display("test levels done");
      hold <= 6'd30;
      iq.push_back(ex(11, 2'h1));
      iq.push_back(ex(0, 2'h2));
      iq.push_back(ex(5, 2'h0));
      req <= 12'h820;
      // Raise the supply monitor while the high routine still runs
      for (n = 0; n < 3000 && iq.size() != 2; n++) @(posedge clk);
      if (n == 3000) tmo();
      req[0] <= 1'b1;
      drain(0);
      rd_reg(12'h340, 34'h7);
      $display("test preemption done");
      results();
   end
endmodule // tb_top
